// [hdl/adc_postproc.sv]
// Purpose: peak hold, dc lowpass decimator and ac mean converter
// Assumes: samples arrive at most one per clock, fast adc mode
// Notes:   multi-byte reads freeze the upper bytes on a low-byte read
`timescale 1ns/100ps
module adc_postproc
  import postproc_pkg::*;
#(
  parameter int HPF_SHIFT = 8
) (
  input  wire logic clk_i,     // system clock
  input  wire logic sys_rst_i, // sync reset, active high
  postproc_if.device bus       // register port and sample stream
);
  localparam int ACC_W = AC_W + RATIO_MAX_LOG2;
  initial begin
    if (HPF_SHIFT < 1 || HPF_SHIFT > 16) $error("adc_postproc: bad HPF_SHIFT");
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] pwr_ctrl_q;
  logic [7:0] ac_ctrl_q;
  wire        wr_pwr  = bus.wr_en && (bus.addr == PWR_CTRL_ADDR);
  wire        wr_ac   = bus.wr_en && (bus.addr == AC_CTRL_ADDR);
  wire        pk_en   = ac_ctrl_q[PK_EN_BIT];
  wire        lp_en   = ac_ctrl_q[LP_EN_BIT];
  wire        ac_en   = ac_ctrl_q[AC_EN_BIT];
  wire        sq_mode = ac_ctrl_q[SQ_BIT];
  wire [1:0]  ratio_sel = ac_ctrl_q[RATIO_LSB +: 2];
  // soft resets are active low, the bit sits at 0 until software restores it
  wire        lp_clr  = !pwr_ctrl_q[LP_SRST_BIT] || !lp_en;
  wire        ac_clr  = !pwr_ctrl_q[AC_SRST_BIT] || !ac_en;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pwr_ctrl_q <= PWR_CTRL_RST;
      ac_ctrl_q  <= AC_CTRL_RST;
    end else begin
      if (wr_pwr) pwr_ctrl_q <= bus.wr_data;
      if (wr_ac)  ac_ctrl_q  <= bus.wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peak hold
  logic [SAMPLE_W-1:0] pk_max, pk_min;
  peak_tracker #(.W(SAMPLE_W), .TRACK_MAX(1'b1), .IDLE_VAL(PK_MAX_RST))
    u_pk_max (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(pk_en),
              .valid_i(bus.sample_valid), .sample_i(bus.sample),
              .peak_o(pk_max));
  peak_tracker #(.W(SAMPLE_W), .TRACK_MAX(1'b0), .IDLE_VAL(PK_MIN_RST))
    u_pk_min (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(pk_en),
              .valid_i(bus.sample_valid), .sample_i(bus.sample),
              .peak_o(pk_min));

  ////////////////////////////////////////////////////////////////////////
  // decimation group counter shared by both paths, so rates match
  logic [RATIO_MAX_LOG2-1:0] grp_cnt_q;
  wire  [RATIO_MAX_LOG2-1:0] grp_last =
    RATIO_MAX_LOG2'((32'd1 << (RATIO_BASE_LOG2 + ratio_sel)) - 1);
  wire        grp_done = bus.sample_valid && (grp_cnt_q == grp_last);
  wire        run      = !(lp_clr && ac_clr);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run) begin
      grp_cnt_q <= '0;
    end else if (bus.sample_valid) begin
      // counts strobes, so any adc output rate is served
      grp_cnt_q <= grp_done ? '0 : grp_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lowpass: boxcar average over the group (sinc1 stand-in, same rate)
  logic signed [SAMPLE_W+RATIO_MAX_LOG2-1:0] lp_acc_q;
  logic        [SAMPLE_W-1:0]                lp_out_q;
  logic                                      lp_evt_q;
  wire signed [SAMPLE_W+RATIO_MAX_LOG2-1:0] lp_sum =
    lp_acc_q + (SAMPLE_W+RATIO_MAX_LOG2)'($signed(bus.sample));
  wire signed [SAMPLE_W+RATIO_MAX_LOG2-1:0] lp_avg =
    lp_sum >>> (RATIO_BASE_LOG2 + ratio_sel);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || lp_clr) begin
      lp_acc_q <= '0;
      lp_out_q <= '0;
      lp_evt_q <= 1'b0;
    end else begin
      lp_evt_q <= grp_done;
      if (grp_done) begin
        lp_acc_q <= '0;
        lp_out_q <= lp_avg[SAMPLE_W-1:0];
      end else if (bus.sample_valid) begin
        lp_acc_q <= lp_sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // high-pass: subtract a slow running dc estimate
  logic signed [SAMPLE_W+HPF_SHIFT-1:0] dc_q;
  wire  signed [SAMPLE_W:0] hp =
    $signed({bus.sample[SAMPLE_W-1], bus.sample})
    - $signed(dc_q[SAMPLE_W+HPF_SHIFT-1 -: SAMPLE_W+1]);
  wire  [SAMPLE_W:0]   hp_abs = hp[SAMPLE_W] ? (SAMPLE_W+1)'(0) - hp : hp;
  wire  [AC_W-1:0]     hp_sq  = AC_W'(hp_abs[SAMPLE_W-1:0])
                              * AC_W'(hp_abs[SAMPLE_W-1:0]);
  wire  [AC_W-1:0]     ac_term = sq_mode ? hp_sq : AC_W'(hp_abs);

  logic [ACC_W-1:0] ac_acc_q;
  logic [AC_W-1:0]  ac_out_q;
  logic             ac_evt_q;
  wire  [ACC_W-1:0] ac_sum = ac_acc_q + ACC_W'(ac_term);
  wire  [ACC_W-1:0] ac_mean = ac_sum >> (RATIO_BASE_LOG2 + ratio_sel);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || ac_clr) begin
      dc_q     <= '0;
      ac_acc_q <= '0;
      ac_out_q <= '0;
      ac_evt_q <= 1'b0;
    end else begin
      ac_evt_q <= grp_done;
      if (bus.sample_valid) begin
        dc_q <= dc_q + (SAMPLE_W+HPF_SHIFT)'(hp);
      end
      if (grp_done) begin
        ac_acc_q <= '0;
        ac_out_q <= ac_mean[AC_W-1:0];
      end else if (bus.sample_valid) begin
        ac_acc_q <= ac_sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback with low-byte freeze of the upper bytes
  logic [SAMPLE_W-1:0] pkmax_frz_q, pkmin_frz_q, lp_frz_q;
  logic [AC_W-1:0]     ac_frz_q;
  logic [7:0]          rd_q;
  wire rd_pkmax = bus.rd_en && (bus.addr == PK_MAX_L_ADDR);
  wire rd_pkmin = bus.rd_en && (bus.addr == PK_MIN_L_ADDR);
  wire rd_ac    = bus.rd_en && (bus.addr == AC_RES_0_ADDR);
  wire rd_lp    = bus.rd_en && (bus.addr == LP_OUT_L_ADDR);
  logic [7:0] rd_mux;
  always_comb begin
    case (bus.addr)
      PWR_CTRL_ADDR:      rd_mux = pwr_ctrl_q;
      AC_CTRL_ADDR:       rd_mux = ac_ctrl_q;
      PK_MAX_U_ADDR:      rd_mux = pkmax_frz_q[18:11];
      PK_MAX_U_ADDR+8'h1: rd_mux = pkmax_frz_q[10:3];
      PK_MAX_L_ADDR:      rd_mux = {5'h0, pk_max[2:0]};
      PK_MIN_U_ADDR:      rd_mux = pkmin_frz_q[18:11];
      PK_MIN_U_ADDR+8'h1: rd_mux = pkmin_frz_q[10:3];
      PK_MIN_L_ADDR:      rd_mux = {5'h0, pk_min[2:0]};
      AC_RES_4_ADDR:      rd_mux = ac_frz_q[37:30];
      AC_RES_4_ADDR+8'h1: rd_mux = ac_frz_q[29:22];
      AC_RES_4_ADDR+8'h2: rd_mux = ac_frz_q[21:14];
      AC_RES_4_ADDR+8'h3: rd_mux = ac_frz_q[13:6];
      AC_RES_0_ADDR:      rd_mux = {2'h0, ac_out_q[5:0]};
      LP_OUT_U_ADDR:      rd_mux = lp_frz_q[18:11];
      LP_OUT_U_ADDR+8'h1: rd_mux = lp_frz_q[10:3];
      LP_OUT_L_ADDR:      rd_mux = {5'h0, lp_out_q[2:0]};
      default:            rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pkmax_frz_q <= PK_MAX_RST;
      pkmin_frz_q <= PK_MIN_RST;
      lp_frz_q    <= '0;
      ac_frz_q    <= '0;
      rd_q        <= 8'h00;
    end else begin
      if (rd_pkmax) pkmax_frz_q <= pk_max;
      if (rd_pkmin) pkmin_frz_q <= pk_min;
      if (rd_ac)    ac_frz_q    <= ac_out_q;
      if (rd_lp)    lp_frz_q    <= lp_out_q;
      if (bus.rd_en) rd_q <= rd_mux;
    end
  end
  assign bus.rd_data          = rd_q;
  assign bus.lp_event         = lp_evt_q;
  assign bus.ac_event         = ac_evt_q;
  assign bus.dec_soft_reset_n = pwr_ctrl_q[DEC_SRST_BIT];
endmodule

// [shared/postproc_pkg.sv]
// Purpose: shared constants for the adc post-processing block and its user
// Assumes: 19-bit signed samples, 8-bit register space
// Notes:   offsets are byte register addresses in the cpu special space
package postproc_pkg;
  localparam int          SAMPLE_W        = 19;
  localparam int          AC_W            = 38;
  localparam int          ADDR_W          = 8;
  // register offsets
  localparam logic [7:0]  PWR_CTRL_ADDR   = 8'h5c;
  localparam logic [7:0]  AC_CTRL_ADDR    = 8'h64;
  localparam logic [7:0]  PK_MAX_U_ADDR   = 8'h6f;
  localparam logic [7:0]  PK_MAX_L_ADDR   = 8'h71;
  localparam logic [7:0]  PK_MIN_U_ADDR   = 8'h72;
  localparam logic [7:0]  PK_MIN_L_ADDR   = 8'h74;
  localparam logic [7:0]  AC_RES_4_ADDR   = 8'h75;
  localparam logic [7:0]  AC_RES_0_ADDR   = 8'h79;
  localparam logic [7:0]  LP_OUT_U_ADDR   = 8'h7a;
  localparam logic [7:0]  LP_OUT_L_ADDR   = 8'h7c;
  // field positions in power_and_filter_reset_control
  localparam int          AC_SRST_BIT     = 0;
  localparam int          LP_SRST_BIT     = 1;
  localparam int          DEC_SRST_BIT    = 2;
  // field positions in ac_lowpass_peak_control
  localparam int          PK_EN_BIT       = 2;
  localparam int          RATIO_LSB       = 3;
  localparam int          SQ_BIT          = 5;
  localparam int          LP_EN_BIT       = 6;
  localparam int          AC_EN_BIT       = 7;
  // reset values
  localparam logic [7:0]  PWR_CTRL_RST    = 8'h07;
  localparam logic [7:0]  AC_CTRL_RST     = 8'h00;
  localparam logic [18:0] PK_MAX_RST      = 19'h40000;
  localparam logic [18:0] PK_MIN_RST      = 19'h3ffff;
  // decimation ratio log2 for code 00; each code step doubles
  localparam int          RATIO_BASE_LOG2 = 8;
  localparam int          RATIO_MAX_LOG2  = 11;
endpackage

// [shared/postproc_if.sv]
// Purpose: byte register port and sample stream between cpu side and block
// Assumes: one clock, all signals synchronous
// Notes:   rd_en is a one-cycle read strobe, rd_data valid next cycle
`timescale 1ns/100ps
interface postproc_if;
  import postproc_pkg::*;
  logic                clk;
  logic                wr_en;
  logic                rd_en;
  logic [ADDR_W-1:0]   addr;
  logic [7:0]          wr_data;
  logic [7:0]          rd_data;
  logic                sample_valid;
  logic [SAMPLE_W-1:0] sample;
  logic                lp_event;
  logic                ac_event;
  logic                dec_soft_reset_n;
  modport device (
    input  wr_en, rd_en, addr, wr_data, sample_valid, sample,
    output rd_data, lp_event, ac_event, dec_soft_reset_n
  );
  modport host (
    output wr_en, rd_en, addr, wr_data, sample_valid, sample,
    input  rd_data, lp_event, ac_event, dec_soft_reset_n
  );
endinterface

// [hdl/peak_tracker.sv]
// Purpose: one signed peak register, max or min direction
// Assumes: sample_valid is a one-cycle strobe
// Notes:   held at its idle code while disabled
`timescale 1ns/100ps
module peak_tracker #(
  parameter int          W        = 19,
  parameter bit          TRACK_MAX = 1'b1,
  parameter logic [18:0] IDLE_VAL = 19'h40000
) (
  input  wire logic         clk_i,   // system clock
  input  wire logic         sys_rst_i, // sync reset
  input  wire logic         en_i,    // tracking enabled
  input  wire logic         valid_i, // new sample
  input  wire logic [W-1:0] sample_i, // sample word
  output logic      [W-1:0] peak_o   // held peak
);
  logic [W-1:0] peak_q;
  // signed compare, so the parked codes are the extremes
  wire          beats = TRACK_MAX ? ($signed(sample_i) > $signed(peak_q))
                                  : ($signed(sample_i) < $signed(peak_q));
  initial begin
    if (W != 19) $error("peak_tracker: width must be 19");
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !en_i) begin
      peak_q <= IDLE_VAL;
    end else if (valid_i && beats) begin
      peak_q <= sample_i;
    end
  end
  assign peak_o = peak_q;
endmodule

// [hdl/postproc_host.sv]
// Purpose: cpu-side end: feeds samples, writes control, reads results
// Assumes: user issues one command at a time
// Notes:   multi-byte reads done low byte first then upward by user
`timescale 1ns/100ps
module postproc_host
  import postproc_pkg::*;
(
  input  wire logic                clk_i,      // system clock
  input  wire logic                sys_rst_i,  // sync reset
  input  wire logic                wr_req_i,   // write request pulse
  input  wire logic                rd_req_i,   // read request pulse
  input  wire logic [7:0]          addr_i,     // register address
  input  wire logic [7:0]          wdata_i,    // write data
  input  wire logic                smp_vld_i,  // sample strobe
  input  wire logic [SAMPLE_W-1:0] smp_i,      // sample word
  output logic      [7:0]          rdata_o,    // read data
  output logic                     rdata_vld_o, // read data valid
  output logic                     lp_evt_o,   // lowpass event seen
  output logic                     ac_evt_o,   // ac event seen
  postproc_if.host                 bus         // link to device
);
  logic       wr_q, rd_q, rd_d1_q, vld_q;
  logic [7:0] addr_q, wd_q, rdata_q;
  logic [SAMPLE_W-1:0] smp_q;
  logic       lp_q, ac_q, rvld_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      rd_d1_q <= 1'b0;
      vld_q   <= 1'b0;
      addr_q  <= 8'h00;
      wd_q    <= 8'h00;
      rdata_q <= 8'h00;
      smp_q   <= '0;
      lp_q    <= 1'b0;
      ac_q    <= 1'b0;
      rvld_q  <= 1'b0;
    end else begin
      wr_q    <= wr_req_i;
      rd_q    <= rd_req_i && !wr_req_i;
      if (wr_req_i || rd_req_i) addr_q <= addr_i;
      if (wr_req_i) wd_q <= wdata_i;
      vld_q   <= smp_vld_i;
      if (smp_vld_i) smp_q <= smp_i;
      rd_d1_q <= rd_q;
      rvld_q  <= rd_d1_q;
      if (rd_d1_q) rdata_q <= bus.rd_data;
      lp_q    <= bus.lp_event;
      ac_q    <= bus.ac_event;
    end
  end
  assign bus.wr_en        = wr_q;
  assign bus.rd_en        = rd_q;
  assign bus.addr         = addr_q;
  assign bus.wr_data      = wd_q;
  assign bus.sample_valid = vld_q;
  assign bus.sample       = smp_q;
  assign rdata_o          = rdata_q;
  assign rdata_vld_o      = rvld_q;
  assign lp_evt_o         = lp_q;
  assign ac_evt_o         = ac_q;
endmodule

// [tb/postproc_chk.sv]
// Purpose: bus-level assertions on the post-processing link
// Assumes: one clock, synchronous active-high reset
// Notes:   shadows both control bytes and the sample group count
`timescale 1ns/100ps
module postproc_chk
  import postproc_pkg::*;
(
  input  wire logic                clk,              // clock
  input  wire logic                sys_rst_i,        // sync reset
  input  wire logic                wr_en,            // write strobe
  input  wire logic                rd_en,            // read strobe
  input  wire logic [ADDR_W-1:0]   addr,             // address
  input  wire logic [7:0]          wr_data,          // write data
  input  wire logic [7:0]          rd_data,          // read data
  input  wire logic                sample_valid,     // sample strobe
  input  wire logic [SAMPLE_W-1:0] sample,           // sample word
  input  wire logic                lp_event,         // lowpass event
  input  wire logic                ac_event,         // ac event
  input  wire logic                dec_soft_reset_n  // comb reset
);
  logic [7:0]  pwr_q;
  logic [7:0]  ctl_q;
  logic [11:0] cnt_q;
  wire         lp_run = ctl_q[LP_EN_BIT] & pwr_q[LP_SRST_BIT];
  wire         ac_run = ctl_q[AC_EN_BIT] & pwr_q[AC_SRST_BIT];
  wire  [11:0] n_val  = 12'h100 << ctl_q[RATIO_LSB+:2];
  // count restarts on every event so it never drifts from the group
  wire  [11:0] cnt_d  = !(lp_run | ac_run) ? 12'h000 :
                        (lp_event | ac_event) ? {11'h0, sample_valid} :
                        cnt_q + {11'h0, sample_valid};
  wire         wr_pwr = wr_en && addr == PWR_CTRL_ADDR;
  wire         wr_ctl = wr_en && addr == AC_CTRL_ADDR;
  always_ff @(posedge clk) begin
    pwr_q <= sys_rst_i ? PWR_CTRL_RST : (wr_pwr ? wr_data : pwr_q);
    ctl_q <= sys_rst_i ? AC_CTRL_RST : (wr_ctl ? wr_data : ctl_q);
    cnt_q <= sys_rst_i ? 12'h000 : cnt_d;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(a);
    rd_en && addr == a;
  endsequence
  a_lp_group_end: assert property (
    lp_run && cnt_q == n_val |-> lp_event)
    else $error("lowpass word missing after full group");
  a_lp_evt_cause: assert property (
    lp_event |-> lp_run && cnt_q == n_val)
    else $error("lowpass event without full group");
  a_ac_evt_cause: assert property (
    ac_event |-> ac_run && cnt_q == n_val)
    else $error("ac event without full group");
  a_ac_same_rate: assert property (
    lp_run && ac_run |-> lp_event == ac_event)
    else $error("ac and lowpass rates differ");
  a_ctl_readback: assert property (
    s_rd(AC_CTRL_ADDR) |=> rd_data == $past(ctl_q))
    else $error("control byte readback wrong");
  a_pwr_readback: assert property (
    s_rd(PWR_CTRL_ADDR) |=> rd_data == $past(pwr_q))
    else $error("reset control readback wrong");
  a_rd_data_hold: assert property (
    !rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  a_dec_rst_follow: assert property (
    wr_pwr |=> dec_soft_reset_n == pwr_q[DEC_SRST_BIT])
    else $error("comb reset level does not follow its bit");
  // one stopped cycle first: the clear lands an edge after the write
  a_lp_off_zero: assert property (
    rd_en && addr == LP_OUT_L_ADDR && !lp_run && !$past(lp_run)
    |=> rd_data == 8'h00)
    else $error("lowpass low byte not zero while stopped");
  a_ac_off_zero: assert property (
    rd_en && addr == AC_RES_0_ADDR && !ac_run && !$past(ac_run)
    |=> rd_data == 8'h00)
    else $error("ac low byte not zero while stopped");
endmodule

// [tb/tb.sv]
// Purpose: drives the host user side and checks the device end
// Assumes: 50 MHz clock, inputs changed on the falling edge
// Notes:   only bits above each result's lowest byte are compared
`timescale 1ns/100ps
module tb;
  import postproc_pkg::*;
  logic                clk_i, sys_rst_i, wr_req, rd_req, smp_vld;
  logic                rdata_vld, lp_evt, ac_evt;
  logic [7:0]          addr, wdata, rdata, b, ctl;
  logic [SAMPLE_W-1:0] smp, c, s, hi, lo;
  logic [31:0]         v, e;
  int                  mismatches, checks, seed;
  localparam int       AMP = 4096;
  postproc_if ifc();
  assign ifc.clk = clk_i;
  // short hpf time constant so the dc estimate settles within one group
  adc_postproc #(.HPF_SHIFT(4)) adc_postproc_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(ifc.device));
  postproc_host postproc_host_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_req_i(wr_req),
    .rd_req_i(rd_req), .addr_i(addr), .wdata_i(wdata), .smp_vld_i(smp_vld),
    .smp_i(smp), .rdata_o(rdata), .rdata_vld_o(rdata_vld),
    .lp_evt_o(lp_evt), .ac_evt_o(ac_evt), .bus(ifc.host));
  postproc_chk postproc_chk_i (
    .clk(ifc.clk), .sys_rst_i(sys_rst_i), .wr_en(ifc.wr_en),
    .rd_en(ifc.rd_en), .addr(ifc.addr), .wr_data(ifc.wr_data),
    .rd_data(ifc.rd_data), .sample_valid(ifc.sample_valid),
    .sample(ifc.sample), .lp_event(ifc.lp_event), .ac_event(ifc.ac_event),
    .dec_soft_reset_n(ifc.dec_soft_reset_n));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got,
                     input logic [31:0] tol = 32'h0);
    checks++;
    if (((got >= ex - tol) && (got <= ex + tol)) !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_i);
    wr_req = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_i);
    wr_req = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_i);
    rd_req = 1'b1;
    addr = a;
    @(negedge clk_i);
    rd_req = 1'b0;
    for (n = 0; n < 8 && rdata_vld !== 1'b1; n++) @(negedge clk_i);
    chk("read_done", 32'h1, 32'(rdata_vld));
    if (rdata_vld !== 1'b1) print_verdict();
    d = rdata;
  endtask
  // low byte first: it freezes the upper bytes of the same value
  task automatic rdv(input logic [7:0] lo_a, input int nb,
                     output logic [31:0] r);
    logic [7:0] t;
    r = '0;
    rd(lo_a, t);
    for (int i = 1; i <= nb; i++) begin
      rd(lo_a - 8'(i), t);
      r[8*(i-1)+:8] = t;
    end
  endtask
  task automatic pk(input logic [18:0] mx, mn);
    rdv(PK_MAX_L_ADDR, 2, v);
    chk("peak_max", 32'(mx[18:3]), v);
    rdv(PK_MIN_L_ADDR, 2, v);
    chk("peak_min", 32'(mn[18:3]), v);
  endtask
  // an ideal hpf leaves +-amp; the bench sees result bits 37:6
  function automatic logic [31:0] ac_expect(input logic sq, input int amp);
    logic [37:0] m;
    m = sq ? 38'(amp) * 38'(amp) : 38'(amp);
    return m[37:6];
  endfunction
  task automatic feed(input logic [SAMPLE_W-1:0] x);
    @(negedge clk_i);
    smp_vld = 1'b1;
    smp = x;
  endtask
  task automatic idle();
    @(negedge clk_i);
    smp_vld = 1'b0;
  endtask
  // one group of samples alternating around dc level cv
  task automatic grp(input logic [SAMPLE_W-1:0] cv, input int n);
    int k;
    for (k = 0; k < n; k++) feed(k[0] ? cv - 19'(AMP) : cv + 19'(AMP));
    idle();
    for (k = 0; k < 8 && lp_evt !== 1'b1; k++) @(negedge clk_i);
    chk("lp_event", 32'h1, 32'(lp_evt));
    chk("ac_event", 32'h1, 32'(ac_evt));
    if (lp_evt !== 1'b1) print_verdict();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h3fea5a99;
    {wr_req, rd_req, smp_vld, addr, wdata, smp} = '0;
    mismatches = 0;
    checks = 0;
    sys_rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(PWR_CTRL_ADDR, b);
    chk("pwr_ctrl", 32'(PWR_CTRL_RST), 32'(b));
    rd(AC_CTRL_ADDR, b);
    chk("ac_ctrl", 32'(AC_CTRL_RST), 32'(b));
    rd(8'h7e, b);
    chk("unmapped", 32'h0, 32'(b));
    pk(PK_MAX_RST, PK_MIN_RST);
    wr(AC_CTRL_ADDR, 8'h04);
    hi = 19'($random(seed));
    lo = hi;
    feed(hi);
    idle();
    pk(hi, lo);
    for (int k = 0; k < 40; k++) begin
      s = (k == 20) ? PK_MAX_RST : 19'($random(seed));
      feed(s);
      if ($signed(s) > $signed(hi)) hi = s;
      if ($signed(s) < $signed(lo)) lo = s;
    end
    idle();
    pk(hi, lo);
    wr(AC_CTRL_ADDR, 8'h00);
    pk(PK_MAX_RST, PK_MIN_RST);
    for (int code = 0; code < 4; code++) begin
      c = 19'h4000 | 19'($random(seed) & 32'h3fff);
      ctl = 8'hc0 | 8'(code << RATIO_LSB) | (code[0] ? 8'h20 : 8'h00);
      wr(AC_CTRL_ADDR, ctl);
      grp(c, 256 << code);
      grp(c, 256 << code);
      rdv(LP_OUT_L_ADDR, 2, v);
      chk("lp_out", 32'(c[18:3]), v);
      rdv(AC_RES_0_ADDR, 4, v);
      e = ac_expect(code[0], AMP);
      chk("ac_out", e, v, e >> 2);
    end
    wr(PWR_CTRL_ADDR, 8'h00);
    rd(PWR_CTRL_ADDR, b);
    chk("pwr_ctrl", 32'h0, 32'(b));
    rdv(LP_OUT_L_ADDR, 2, v);
    chk("lp_cleared", 32'h0, v);
    rdv(AC_RES_0_ADDR, 4, v);
    chk("ac_cleared", 32'h0, v);
    wr(PWR_CTRL_ADDR, PWR_CTRL_RST);
    grp(c, 2048);
    rdv(LP_OUT_L_ADDR, 2, v);
    chk("lp_back", 32'(c[18:3]), v);
    wr(AC_CTRL_ADDR, 8'h00);
    rdv(LP_OUT_L_ADDR, 2, v);
    chk("lp_off", 32'h0, v);
    rdv(AC_RES_0_ADDR, 4, v);
    chk("ac_off", 32'h0, v);
    print_verdict();
  end
endmodule
